// ==== src/lcdc_pkg.sv ====
// Functional notes
// - Host drive register at 74h, reset 00h, bits 5..0 steer unlinked channels.
// - A linked channel ignores its host drive bit.
// - Drive bit 0 gives minimum duty, 1 actuates at maximum or behaviour duty.
// - Resting level follows polarity; actuated waveform comes from the behaviour duty.
// - A low pin means the lamp is lit and sinking current.
// - Inverted and resting, pin is low for the minimum-duty share of each period.
// - Transition register at 77h, reset 00h, one handover bit per channel.
// - Transition 0: linking a host-lit channel without touch changes its state.
// - Transition 1 with invert set: state kept on link, later touch toggles it.
// - Transition 1 with invert clear: state kept on link, touch has no effect.
// - Duty-mirror register at 79h, reset 00h; 1 counts duty from 100%.
// - Mirrored channels apply minimum and maximum duty relative to 100%.
// - Polarity change copies into mirror bit unless polarity follow is blocked.
// - Actuated, polarity 0 drives low; polarity 1 drives high or floats.
// - Unlinked host bit 1 is a touch trigger, 0 a release trigger.
package lcdc_pkg;
   localparam int NUM_CH = 6;
   localparam int DUTY_W = 7;
   localparam logic [7:0] ADDR_HOST_DRIVE = 8'h74;
   localparam logic [7:0] ADDR_LINK_TRAN = 8'h77;
   localparam logic [7:0] ADDR_DUTY_MIRROR = 8'h79;
   localparam logic [5:0] RESET_HOST_DRIVE = 6'h00;
   localparam logic [5:0] RESET_LINK_TRAN = 6'h00;
   localparam logic [5:0] RESET_DUTY_MIRROR = 6'h00;
   localparam logic [1:0] RESERVED_READ = 2'h0;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64;
   localparam logic [DUTY_W-1:0] PERIOD_LAST = 7'h63;
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 7'h00;
   localparam logic [DUTY_W-1:0] DUTY_STEP = 7'h01;
   localparam logic [7:0] READ_IDLE = 8'h00;
endpackage : lcdc_pkg

// ==== src/lcdc_channel.sv ====
`timescale 1ns/1ps
module lcdc_channel (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Controls
   input wire logic host_actuate,
   input wire logic linked,
   input wire logic touch,
   input wire logic link_transition,
   input wire logic invert_link_handover,
   input wire logic polarity,
   input wire logic duty_mirror,
   input wire logic open_drain,
   // Duty
   input wire logic [lcdc_pkg::DUTY_W-1:0] min_duty,
   input wire logic [lcdc_pkg::DUTY_W-1:0] act_duty,
   input wire logic [lcdc_pkg::DUTY_W-1:0] pwm_count,
   // Results
   output logic actuate,
   output logic pin_out,
   output logic pin_oe_n
);
   logic linked_prev;
   logic held_state;
   logic next_linked_prev;
   logic next_held_state;
   logic next_actuate;
   logic next_pin_out;
   logic next_pin_oe_n;
   logic [lcdc_pkg::DUTY_W-1:0] duty;
   logic [lcdc_pkg::DUTY_W-1:0] eff_duty;
   logic active_level;
   logic level;

   always_comb begin
      next_linked_prev = linked;
      next_held_state = held_state;
      if (linked && !linked_prev) begin
         next_held_state = host_actuate;
      end
      if (!linked) begin
         next_actuate = host_actuate;
      end else if (!link_transition) begin
         next_actuate = touch;
      end else if (invert_link_handover) begin
         next_actuate = next_held_state ^ touch;
      end else begin
         next_actuate = next_held_state;
      end
      duty = actuate ? act_duty : min_duty;
      eff_duty = duty_mirror ? lcdc_pkg::DUTY_FULL - duty : duty;
      active_level = pwm_count < eff_duty;
      level = polarity ? active_level : !active_level;
      next_pin_out = level;
      next_pin_oe_n = open_drain && level;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         linked_prev <= 1'b0;
         held_state <= 1'b0;
         actuate <= 1'b0;
         pin_out <= 1'b1;
         pin_oe_n <= 1'b0;
      end else begin
         linked_prev <= next_linked_prev;
         held_state <= next_held_state;
         actuate <= next_actuate;
         pin_out <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
      end
   end
endmodule : lcdc_channel

// ==== src/lcdc_top.sv ====
`timescale 1ns/1ps
module lcdc_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register access port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Controls held elsewhere in the device
   input wire logic [lcdc_pkg::NUM_CH-1:0] link_enable,
   input wire logic [lcdc_pkg::NUM_CH-1:0] polarity,
   input wire logic [lcdc_pkg::NUM_CH-1:0] open_drain,
   input wire logic invert_link_handover,
   input wire logic block_polarity_follow,
   // Sensing and behaviour engine
   input wire logic [lcdc_pkg::NUM_CH-1:0] touch_input,
   input wire logic [lcdc_pkg::NUM_CH*lcdc_pkg::DUTY_W-1:0] min_duty,
   input wire logic [lcdc_pkg::NUM_CH*lcdc_pkg::DUTY_W-1:0] act_duty,
   output logic [lcdc_pkg::NUM_CH-1:0] actuate,
   // Lamp pins
   output logic [lcdc_pkg::NUM_CH-1:0] lamp_output,
   output logic [lcdc_pkg::NUM_CH-1:0] lamp_output_oe_n
);
   logic [lcdc_pkg::NUM_CH-1:0] host_drive;
   logic [lcdc_pkg::NUM_CH-1:0] link_transition;
   logic [lcdc_pkg::NUM_CH-1:0] duty_mirror;
   logic [lcdc_pkg::NUM_CH-1:0] polarity_prev;
   logic [lcdc_pkg::DUTY_W-1:0] pwm_count;
   logic [lcdc_pkg::NUM_CH-1:0] next_host_drive;
   logic [lcdc_pkg::NUM_CH-1:0] next_link_transition;
   logic [lcdc_pkg::NUM_CH-1:0] next_duty_mirror;
   logic [lcdc_pkg::NUM_CH-1:0] next_polarity_prev;
   logic [lcdc_pkg::DUTY_W-1:0] next_pwm_count;
   logic [7:0] next_reg_rdata;
   logic [lcdc_pkg::NUM_CH-1:0] pol_changed;

   always_comb begin
      next_host_drive = host_drive;
      next_link_transition = link_transition;
      next_duty_mirror = duty_mirror;
      next_polarity_prev = polarity;
      next_reg_rdata = lcdc_pkg::READ_IDLE;
      if (reg_wr) begin
         if (reg_addr == lcdc_pkg::ADDR_HOST_DRIVE) begin
            next_host_drive = reg_wdata[lcdc_pkg::NUM_CH-1:0];
         end else if (reg_addr == lcdc_pkg::ADDR_LINK_TRAN) begin
            next_link_transition = reg_wdata[lcdc_pkg::NUM_CH-1:0];
         end else if (reg_addr == lcdc_pkg::ADDR_DUTY_MIRROR) begin
            next_duty_mirror = reg_wdata[lcdc_pkg::NUM_CH-1:0];
         end
      end
      // Follow from polarity wins over a host write in the same cycle
      pol_changed = polarity ^ polarity_prev;
      if (!block_polarity_follow) begin
         next_duty_mirror = (next_duty_mirror & ~pol_changed) | (polarity & pol_changed);
      end
      if (reg_rd) begin
         if (reg_addr == lcdc_pkg::ADDR_HOST_DRIVE) begin
            next_reg_rdata = {lcdc_pkg::RESERVED_READ, host_drive};
         end else if (reg_addr == lcdc_pkg::ADDR_LINK_TRAN) begin
            next_reg_rdata = {lcdc_pkg::RESERVED_READ, link_transition};
         end else if (reg_addr == lcdc_pkg::ADDR_DUTY_MIRROR) begin
            next_reg_rdata = {lcdc_pkg::RESERVED_READ, duty_mirror};
         end
      end
      if (pwm_count == lcdc_pkg::PERIOD_LAST) begin
         next_pwm_count = lcdc_pkg::DUTY_ZERO;
      end else begin
         next_pwm_count = pwm_count + lcdc_pkg::DUTY_STEP;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_drive <= lcdc_pkg::RESET_HOST_DRIVE;
         link_transition <= lcdc_pkg::RESET_LINK_TRAN;
         duty_mirror <= lcdc_pkg::RESET_DUTY_MIRROR;
         polarity_prev <= '0;
         pwm_count <= lcdc_pkg::DUTY_ZERO;
         reg_rdata <= lcdc_pkg::READ_IDLE;
      end else begin
         host_drive <= next_host_drive;
         link_transition <= next_link_transition;
         duty_mirror <= next_duty_mirror;
         polarity_prev <= next_polarity_prev;
         pwm_count <= next_pwm_count;
         reg_rdata <= next_reg_rdata;
      end
   end

   for (genvar ch = 0; ch < lcdc_pkg::NUM_CH; ch++) begin : g_ch
      lcdc_channel u_channel (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .host_actuate(host_drive[ch]),
         .linked(link_enable[ch]),
         .touch(touch_input[ch]),
         .link_transition(link_transition[ch]),
         .invert_link_handover(invert_link_handover),
         .polarity(polarity[ch]),
         .duty_mirror(duty_mirror[ch]),
         .open_drain(open_drain[ch]),
         .min_duty(min_duty[ch*lcdc_pkg::DUTY_W +: lcdc_pkg::DUTY_W]),
         .act_duty(act_duty[ch*lcdc_pkg::DUTY_W +: lcdc_pkg::DUTY_W]),
         .pwm_count(pwm_count),
         .actuate(actuate[ch]),
         .pin_out(lamp_output[ch]),
         .pin_oe_n(lamp_output_oe_n[ch])
      );
   end
endmodule : lcdc_top

// ==== verif/lcdc_chk.sv ====
`timescale 1ns/1ps
module lcdc_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Watched ports
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [5:0] link_enable,
   input wire logic [5:0] touch_input,
   input wire logic [5:0] open_drain,
   input wire logic [5:0] actuate,
   input wire logic [5:0] lamp_output,
   input wire logic [5:0] lamp_output_oe_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   rsvd_zero_a: assert property (reg_rdata[7:6] == 2'h0)
      else $error("reserved bits set");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("data without read");
   rd_back_a: assert property (reg_wr && reg_addr == 8'h77 ##1 reg_rd && !reg_wr && reg_addr == 8'h77 |=>
      reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)}) else $error("read back differs");
   host_follow_a: assert property (reg_wr && reg_addr == 8'h74 && !link_enable[0] ##1 !link_enable[0] |=>
      actuate[0] == $past(reg_wdata[0], 2)) else $error("host bit not followed");
   host_hold_a: assert property (!link_enable[0] && !$past(link_enable[0]) && !$past(reg_wr) |=> $stable(actuate[0]))
      else $error("unlinked request moved");
   link_ignore_a: assert property (link_enable[0] && $stable(link_enable[0]) && $past(link_enable[0], 2)
      && $stable(touch_input[0]) |=> $stable(actuate[0])) else $error("linked request moved");
   oe_level_a: assert property (lamp_output_oe_n[2] |-> lamp_output[2])
      else $error("released while low");
   oe_drive_a: assert property (!$past(open_drain[2]) |-> !lamp_output_oe_n[2])
      else $error("push-pull released");
endmodule : lcdc_chk
bind lcdc_top lcdc_chk i_chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_enable,
   .touch_input, .open_drain, .actuate, .lamp_output, .lamp_output_oe_n);

// ==== verif/lcdc_lamp_model.sv ====
`timescale 1ns/1ps
module lcdc_lamp_model (
   // Lamp pins
   input wire logic sys_clk,
   input wire logic [5:0] lamp_output,
   input wire logic [5:0] lamp_output_oe_n,
   // Lit cycles per lamp
   output int lit_cnt [6]
);
   // Released pin is pulled up; a low pin sinks lamp current
   always @(posedge sys_clk) begin
      for (int i = 0; i < 6; i++) begin
         lit_cnt[i] <= lit_cnt[i] + int'(!(lamp_output[i] | lamp_output_oe_n[i]));
      end
   end
endmodule : lcdc_lamp_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_q = 0, invert_link_handover = 0, block_polarity_follow = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, exp_q [$], a [3] = '{8'h74, 8'h77, 8'h79};
   logic [5:0] link_enable = 0, polarity = 0, open_drain = 0, touch_input = 0, actuate, lamp_output, lamp_output_oe_n;
   logic [41:0] min_duty, act_duty;
   int lit_cnt [6], snap [6], mismatches = 0, cmp_count = 0, seed = 32'h0099, e;
   lcdc_top i_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_enable, .polarity,
      .open_drain, .invert_link_handover, .block_polarity_follow, .touch_input, .min_duty, .act_duty, .actuate,
      .lamp_output, .lamp_output_oe_n);
   lcdc_lamp_model i_lamp (.sys_clk, .lamp_output, .lamp_output_oe_n, .lit_cnt);
   always #4 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      cmp_count++;
      if (g !== x) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic acc(input bit w, input logic [7:0] ad, input logic [7:0] d, input logic [7:0] x);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= w;
      if (w) begin
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
      reg_rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask : acc
   task automatic meas(input bit use_act, input logic [5:0] flip);
      repeat (103) @(posedge sys_clk);
      snap = lit_cnt;
      repeat (100) @(posedge sys_clk);
      for (int i = 0; i < 6; i++) begin
         e = use_act ? act_duty[7*i+:7] : min_duty[7*i+:7];
         chk(8'(lit_cnt[i] - snap[i]), 8'(flip[i] ? 100 - e : e));
      end
   endtask : meas
   task automatic tally_and_finish();
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge sys_clk) begin
      rd_q <= reg_rd;
      if (rd_q) begin
         chk(reg_rdata, exp_q.pop_front());
      end
   end
   initial begin
      #40000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      for (int i = 0; i < 42; i += 7) begin
         min_duty[i+:7] <= 7'($unsigned($random(seed)) % 101);
         act_duty[i+:7] <= 7'($unsigned($random(seed)) % 101);
      end
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int j = 0; j < 3; j++) begin
         acc(0, a[j], 8'h00, 8'h00);
         acc(1, a[j], 8'hFF, 8'h3F);
      end
      acc(1, 8'h75, 8'hFF, 8'h00);
      meas(1, 6'h3F);
      for (int m = 0; m < 3; m++) begin
         invert_link_handover <= m == 1;
         acc(1, 8'h77, m ? 8'h3F : 8'h00, m ? 8'h3F : 8'h00);
         acc(1, 8'h74, 8'h3F, 8'h3F);
         chk({2'h0, actuate}, 8'h3F);
         link_enable <= 6'h3F;
         repeat (3) @(posedge sys_clk);
         chk({2'h0, actuate}, m ? 8'h3F : 8'h00);
         acc(1, 8'h74, 8'h00, 8'h00);
         touch_input <= 6'h3F;
         repeat (3) @(posedge sys_clk);
         chk({2'h0, actuate}, m == 1 ? 8'h00 : 8'h3F);
         {link_enable, touch_input} <= 12'h000;
         acc(0, 8'h74, 8'h00, 8'h00);
         chk({2'h0, actuate}, 8'h00);
      end
      acc(1, 8'h79, 8'h00, 8'h00);
      meas(0, 6'h00);
      polarity <= 6'h0C;
      open_drain <= 6'h0C;
      // Mirror copy lands one edge after the polarity change
      @(posedge sys_clk);
      acc(0, 8'h79, 8'h00, 8'h0C);
      meas(0, 6'h00);
      acc(1, 8'h74, 8'h3F, 8'h3F);
      meas(1, 6'h00);
      block_polarity_follow <= 1'b1;
      polarity <= 6'h00;
      @(posedge sys_clk);
      acc(0, 8'h79, 8'h00, 8'h0C);
      tally_and_finish();
   end
endmodule : testbench
